// *** core/aea_pkg.sv ***
// Package: constants, register map and carrier types of the apparent energy block
package aea_pkg;
  localparam int NPH = 3;
  // Timing
  localparam longint CLK_HZ   = 100_000_000;
  localparam longint ACC_HZ   = 1_024_000;
  localparam logic [16:0] TICK_INC = 17'(ACC_HZ / 1000);
  localparam logic [16:0] TICK_MOD = 17'(CLK_HZ / 1000);
  // Power scaling
  localparam longint FULL_SCALE_POWER_CONSTANT      = 27_059_678;
  localparam longint RMS_FS    = 3_766_572;
  localparam int     K_SHIFT   = 36;
  localparam int     PWR_SHIFT = K_SHIFT + 12;
  // Scale factor kept to 8 extra fraction bits so the full-scale word lands within one code
  localparam longint PWR_Q     = (FULL_SCALE_POWER_CONSTANT <<< K_SHIFT) / (RMS_FS * RMS_FS);
  localparam longint PWR_R     = (FULL_SCALE_POWER_CONSTANT <<< K_SHIFT) % (RMS_FS * RMS_FS);
  localparam logic [27:0] PWR_K = 28'((PWR_Q <<< 8) + ((PWR_R <<< 8) / (RMS_FS * RMS_FS)));
  localparam int     GAIN_SHIFT = 23;
  localparam int     THR_ZEROS  = 27;
  localparam int     ACC_W      = 36;
  // Register offsets
  localparam logic [7:0] OFS_THR     = 8'h00;
  localparam logic [7:0] OFS_NOMINAL_VOLTAGE_WORD    = 8'h04;
  localparam logic [7:0] OFS_COMP    = 8'h08;
  localparam logic [7:0] OFS_LCYC    = 8'h0c;
  localparam logic [7:0] OFS_HALF_CYCLE_COUNT_WORD = 8'h10;
  localparam logic [7:0] OFS_MASK    = 8'h14;
  localparam logic [7:0] OFS_STATUS  = 8'h18;
  localparam logic [7:0] OFS_ETOT    = 8'h1c;
  localparam logic [7:0] OFS_IPWR    = 8'h28;
  localparam logic [7:0] OFS_GAIN    = 8'h34;
  localparam logic [7:0] OFS_END     = 8'h40;
  // Field positions
  localparam int COMP_NOMINAL_VOLTAGE_WORD_LSB = 11;
  localparam int LCYC_LVA      = 2;
  localparam int LCYC_ZX_LSB   = 3;
  localparam int LCYC_RCLR     = 6;
  localparam int ST_HALF_FULL  = 4;
  localparam int ST_LC_DONE    = 5;
  // Reset values, half-full preset and bus response codes
  localparam logic [7:0]  THR_RST     = 8'h03;
  localparam logic [23:0] NOMINAL_VOLTAGE_WORD_RST    = 24'h000000;
  localparam logic [15:0] HALF_CYCLE_COUNT_WORD_RST = 16'hffff;
  localparam logic [31:0] HALF_PRE    = 32'h3fffffff;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic signed [23:0] v_rms;
    logic signed [23:0] i_rms;
  } aea_meas_t;
endpackage : aea_pkg

// *** core/aea_apparent_energy.sv ***
// Apparent power and VA-hour accumulation with AXI4-Lite register access
`timescale 1ns/10ps
`default_nettype none
module aea_apparent_energy (
  // Clock and reset
  input  wire  logic                                    aclk,
  input  wire  logic                                    aresetn,
  // AXI4-Lite write channels
  input  wire  logic [7:0]                              s_axi_awaddr,
  input  wire  logic                                    s_axi_awvalid,
  output logic                                          s_axi_awready,
  input  wire  logic [31:0]                             s_axi_wdata,
  input  wire  logic [3:0]                              s_axi_wstrb,
  input  wire  logic                                    s_axi_wvalid,
  output logic                                          s_axi_wready,
  output logic [1:0]                                    s_axi_bresp,
  output logic                                          s_axi_bvalid,
  input  wire  logic                                    s_axi_bready,
  // AXI4-Lite read channels
  input  wire  logic [7:0]                              s_axi_araddr,
  input  wire  logic                                    s_axi_arvalid,
  output logic                                          s_axi_arready,
  output logic [31:0]                                   s_axi_rdata,
  output logic [1:0]                                    s_axi_rresp,
  output logic                                          s_axi_rvalid,
  input  wire  logic                                    s_axi_rready,
  // Measurements from the rms stage
  input  wire  aea_pkg::aea_meas_t [aea_pkg::NPH-1:0]   meas,
  input  wire  logic                                    sample_stb,
  input  wire  logic [aea_pkg::NPH-1:0]                 zero_cross,
  // Outputs
  output logic [aea_pkg::NPH-1:0]                       energy_pulse,
  output logic                                          interrupt_out_n
);
  localparam int N = aea_pkg::NPH;

  logic [7:0]        thr_r;
  logic [23:0]       nominal_voltage_word_r;
  logic [2:0]        nominal_use_r;
  logic [2:0]        zx_sel_r;
  logic              lva_r;
  logic              rclr_r;
  logic [15:0]       half_cycle_count_word_r;
  logic [31:0]       mask_r;
  logic [5:4]        status_r;
  logic [23:0]       gain_r [N];
  logic [23:0]       ipwr_r [N];
  logic [31:0]       cnt_r [N];
  logic [31:0]       total_r [N];
  logic [N-1:0]      half_ev;
  logic [N-1:0]      rd_hit;
  logic [N-1:0]      pulse_vec;
  logic [31:0]       thr_m;
  logic [31:0]       nominal_voltage_word_m;
  logic [31:0]       comp_m;
  logic [31:0]       lcyc_m;
  logic [31:0]       half_cycle_count_word_m;
  logic [16:0]       frac_r;
  logic              tick_r;
  logic [15:0]       lc_cnt_r;
  logic              lc_done;

  // Bus handshake state
  logic              aw_held_r;
  logic              w_held_r;
  logic [7:0]        awaddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;
  logic              do_write;
  logic              ar_fire;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) res[8*b +: 8] = nw[8*b +: 8];
    end
    return res;
  endfunction : merge

  function automatic logic mapped(input logic [7:0] a);
    return (a < aea_pkg::OFS_END) && (a[1:0] == 2'b00);
  endfunction : mapped

  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign do_write      = aw_held_r && w_held_r && !bvalid_r;
  assign ar_fire       = s_axi_arvalid && !rvalid_r;
  assign thr_m         = merge({24'h0, thr_r}, wdata_r, wstrb_r);
  assign nominal_voltage_word_m        = merge({8'h0, nominal_voltage_word_r}, wdata_r, wstrb_r);
  assign comp_m        = merge({18'h0, nominal_use_r, 11'h0}, wdata_r, wstrb_r);
  assign lcyc_m        = merge({25'h0, rclr_r, zx_sel_r, lva_r, 2'h0}, wdata_r, wstrb_r);
  assign half_cycle_count_word_m     = merge({16'h0, half_cycle_count_word_r}, wdata_r, wstrb_r);

  // Write address and data are taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= aea_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r  <= mapped(awaddr_r) ? aea_pkg::RESP_OKAY : aea_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thr_r         <= aea_pkg::THR_RST;
      nominal_voltage_word_r        <= aea_pkg::NOMINAL_VOLTAGE_WORD_RST;
      nominal_use_r <= 3'h0;
      zx_sel_r      <= 3'h0;
      lva_r         <= 1'b0;
      rclr_r        <= 1'b0;
      half_cycle_count_word_r     <= aea_pkg::HALF_CYCLE_COUNT_WORD_RST;
      mask_r        <= 32'h00000000;
    end else if (do_write) begin
      unique case (awaddr_r)
        aea_pkg::OFS_THR: thr_r <= thr_m[7:0];
        aea_pkg::OFS_NOMINAL_VOLTAGE_WORD: nominal_voltage_word_r <= nominal_voltage_word_m[23:0];
        aea_pkg::OFS_COMP: begin
          nominal_use_r <= comp_m[aea_pkg::COMP_NOMINAL_VOLTAGE_WORD_LSB +: 3];
        end
        aea_pkg::OFS_LCYC: begin
          zx_sel_r <= lcyc_m[aea_pkg::LCYC_ZX_LSB +: 3];
          lva_r    <= lcyc_m[aea_pkg::LCYC_LVA];
          rclr_r   <= lcyc_m[aea_pkg::LCYC_RCLR];
        end
        aea_pkg::OFS_HALF_CYCLE_COUNT_WORD: half_cycle_count_word_r <= half_cycle_count_word_m[15:0];
        aea_pkg::OFS_MASK: mask_r <= merge(mask_r, wdata_r, wstrb_r);
        default: ;
      endcase
    end
  end

  // Status flags: a set in the clearing cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= 2'b00;
    end else begin
      logic [5:4] clr;
      clr = 2'b00;
      if (do_write && awaddr_r == aea_pkg::OFS_STATUS && wstrb_r[0]) begin
        clr = wdata_r[5:4];
      end
      status_r[aea_pkg::ST_HALF_FULL] <= (status_r[aea_pkg::ST_HALF_FULL] & ~clr[4]) | (|half_ev);
      status_r[aea_pkg::ST_LC_DONE]   <= (status_r[aea_pkg::ST_LC_DONE] & ~clr[5]) | lc_done;
    end
  end

  assign interrupt_out_n = !(|(status_r & mask_r[5:4]));

  // Accumulation tick at 1.024 MHz from the 100 MHz clock by fractional stepping
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frac_r <= 17'h00000;
      tick_r <= 1'b0;
    end else if (frac_r + aea_pkg::TICK_INC >= aea_pkg::TICK_MOD) begin
      frac_r <= frac_r + aea_pkg::TICK_INC - aea_pkg::TICK_MOD;
      tick_r <= 1'b1;
    end else begin
      frac_r <= frac_r + aea_pkg::TICK_INC;
      tick_r <= 1'b0;
    end
  end

  // Half line cycle counter
  assign lc_done = lva_r && (|(zero_cross & zx_sel_r)) && (lc_cnt_r + 16'h0001 >= half_cycle_count_word_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lc_cnt_r <= 16'h0000;
    end else if (!lva_r || lc_done) begin
      lc_cnt_r <= 16'h0000;
    end else if (|(zero_cross & zx_sel_r)) begin
      lc_cnt_r <= lc_cnt_r + 16'h0001;
    end
  end

  // Per-phase datapath
  for (genvar g = 0; g < N; g++) begin : g_ph
    logic signed [23:0]       v_eff;
    logic signed [47:0]       prod;
    logic signed [76:0]       scl;
    logic [31:0]              gain_m;
    logic signed [24:0]       raw;
    logic signed [48:0]       gp;
    logic signed [25:0]       adj;
    logic signed [aea_pkg::ACC_W-1:0] acc_r;
    logic signed [aea_pkg::ACC_W-1:0] acc_sum;
    logic signed [aea_pkg::ACC_W-1:0] thr_full;
    logic                     pulse;
    logic [31:0]              cnt_inc;

    assign v_eff = nominal_use_r[g] ? nominal_voltage_word_r : meas[g].v_rms;
    assign prod  = v_eff * meas[g].i_rms;
    assign scl   = prod * $signed({1'b0, aea_pkg::PWR_K});
    assign raw   = 25'(scl >>> aea_pkg::PWR_SHIFT);
    assign gp    = raw * $signed(gain_r[g]);
    assign adj   = 26'(raw) + 26'(gp >>> aea_pkg::GAIN_SHIFT);

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ipwr_r[g] <= 24'h000000;
      end else if (sample_stb) begin
        ipwr_r[g] <= adj[23:0];
      end
    end

    assign thr_full = $signed({1'b0, thr_r, {aea_pkg::THR_ZEROS{1'b0}}});
    assign acc_sum  = acc_r + (tick_r ? aea_pkg::ACC_W'($signed(ipwr_r[g])) : '0);
    assign pulse    = acc_sum >= thr_full;
    assign pulse_vec[g] = pulse;
    assign gain_m   = merge({8'h0, gain_r[g]}, wdata_r, wstrb_r);

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        acc_r           <= '0;
        energy_pulse[g] <= 1'b0;
      end else begin
        acc_r           <= pulse ? acc_sum - thr_full : acc_sum;
        energy_pulse[g] <= pulse;
      end
    end

    assign cnt_inc   = cnt_r[g] + {31'h0, pulse};
    assign half_ev[g] = pulse && cnt_r[g] == aea_pkg::HALF_PRE;
    assign rd_hit[g] = ar_fire && s_axi_araddr == aea_pkg::OFS_ETOT + 8'(4 * g);

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cnt_r[g]   <= 32'h00000000;
        total_r[g] <= 32'h00000000;
      end else if (lva_r) begin
        if (lc_done) begin
          total_r[g] <= cnt_inc;
          cnt_r[g]   <= {31'h0, 1'b0};
        end else begin
          cnt_r[g] <= cnt_inc;
        end
      end else begin
        if (rd_hit[g]) begin
          total_r[g] <= cnt_inc;
        end
        cnt_r[g] <= (rd_hit[g] && rclr_r) ? 32'h00000000 : cnt_inc;
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        gain_r[g] <= 24'h000000;
      end else if (do_write && awaddr_r == aea_pkg::OFS_GAIN + 8'(4 * g)) begin
        gain_r[g] <= gain_m[23:0];
      end
    end
  end

  // Read data; an energy read in accumulation mode returns the value copied by this access
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= aea_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_r <= 1'b1;
      rresp_r  <= mapped(s_axi_araddr) ? aea_pkg::RESP_OKAY : aea_pkg::RESP_SLVERR;
      rdata_r  <= 32'h00000000;
      for (int p = 0; p < N; p++) begin
        if (s_axi_araddr == aea_pkg::OFS_ETOT + 8'(4 * p)) begin
          rdata_r <= lva_r ? total_r[p] : cnt_r[p] + {31'h0, pulse_vec[p]};
        end
        if (s_axi_araddr == aea_pkg::OFS_IPWR + 8'(4 * p)) rdata_r <= {8'h00, ipwr_r[p]};
        if (s_axi_araddr == aea_pkg::OFS_GAIN + 8'(4 * p)) rdata_r <= {8'h00, gain_r[p]};
      end
      unique case (s_axi_araddr)
        aea_pkg::OFS_THR:     rdata_r <= {24'h0, thr_r};
        aea_pkg::OFS_NOMINAL_VOLTAGE_WORD:    rdata_r <= {8'h00, nominal_voltage_word_r};
        aea_pkg::OFS_COMP:    rdata_r <= {18'h0, nominal_use_r, 11'h0};
        aea_pkg::OFS_LCYC:    rdata_r <= {25'h0, rclr_r, zx_sel_r, lva_r, 2'h0};
        aea_pkg::OFS_HALF_CYCLE_COUNT_WORD: rdata_r <= {16'h0, half_cycle_count_word_r};
        aea_pkg::OFS_MASK:    rdata_r <= mask_r;
        aea_pkg::OFS_STATUS:  rdata_r <= {26'h0, status_r, 4'h0};
        default: ;
      endcase
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule : aea_apparent_energy
`default_nettype wire

// *** verif/aea_host.sv ***
// Host model: AXI4-Lite master that reaches the register map
`timescale 1ns/10ps
`default_nettype none
module aea_host (
  // Clock
  input  wire logic        aclk,
  // Write channels
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // Read channels
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : aea_host
`default_nettype wire

// *** verif/aea_apparent_energy_assertions.sv ***
// Checker: port-level assertions for the apparent energy block
`timescale 1ns/10ps
`default_nettype none
module aea_apparent_energy_assertions (
  // Clock and reset
  input wire logic                      aclk,
  input wire logic                      aresetn,
  // Bus handshakes
  input wire logic                      s_axi_awready,
  input wire logic                      s_axi_wready,
  input wire logic                      s_axi_bvalid,
  input wire logic                      s_axi_bready,
  input wire logic                      s_axi_arvalid,
  input wire logic                      s_axi_arready,
  input wire logic [31:0]               s_axi_rdata,
  input wire logic                      s_axi_rvalid,
  input wire logic                      s_axi_rready,
  // Outputs
  input wire logic [aea_pkg::NPH-1:0]   energy_pulse,
  input wire logic                      interrupt_out_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_rd_answer;
    s_axi_rvalid && !s_axi_arready;
  endsequence
  property p_rd_answer;
    s_rd_take |=> s_rd_answer;
  endproperty
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_wr_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  property p_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_ar_free;
    !s_axi_rvalid |-> s_axi_arready;
  endproperty
  property p_rst;
    disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && energy_pulse == '0 && interrupt_out_n;
  endproperty
  property p_pulse;
    energy_pulse[0] |=> !energy_pulse[0] [*8];
  endproperty
  property p_irq_rel;
    $rose(interrupt_out_n) |-> s_axi_bvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered next cycle");
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped before rready");
  a_wr_hold: assert property (p_wr_hold) else $error("write response dropped before bready");
  a_refuse: assert property (p_refuse) else $error("write channel ready during response");
  a_ar_free: assert property (p_ar_free) else $error("read address refused while idle");
  a_rst: assert property (p_rst) else $error("outputs not at reset values");
  a_pulse: assert property (p_pulse) else $error("energy pulse longer than one cycle");
  a_irq_rel: assert property (p_irq_rel) else $error("interrupt released without a write");
endmodule : aea_apparent_energy_assertions

bind aea_apparent_energy aea_apparent_energy_assertions i_chk (
  .aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .energy_pulse, .interrupt_out_n
);
`default_nettype wire

// *** verif/aea_apparent_energy_test.sv ***
// Testbench: register, power and energy scenarios for the apparent energy block
`timescale 1ns/10ps
`default_nettype none
module aea_apparent_energy_test;
  logic                                  aclk;
  logic                                  aresetn;
  logic [7:0]                            s_axi_awaddr, s_axi_araddr;
  logic [31:0]                           s_axi_wdata, s_axi_rdata, d, d0;
  logic [3:0]                            s_axi_wstrb;
  logic [1:0]                            s_axi_bresp, s_axi_rresp, r;
  logic                                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                                  s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                                  s_axi_rvalid, s_axi_rready, sample_stb, interrupt_out_n;
  aea_pkg::aea_meas_t [aea_pkg::NPH-1:0] meas;
  logic [aea_pkg::NPH-1:0]               zero_cross, energy_pulse;
  int                                    fails = 0, checks_done = 0, npulse = 0, n0;

  aea_apparent_energy i_aea_apparent_energy (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .meas, .sample_stb, .zero_cross, .energy_pulse, .interrupt_out_n
  );
  aea_host i_aea_host (
    .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  initial aclk = 1'b0;
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    if (energy_pulse[0] === 1'b1) npulse <= npulse + 1;
  end

  task automatic results;
    if (fails == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  task automatic near(input logic [31:0] got, input int exp, input int tol);
    checks_done++;
    if ($isunknown(got) || int'(got) > exp + tol || int'(got) < exp - tol) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : near

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    near(got, int'(exp), 0);
  endtask : chk

  task automatic pulse(input logic s, input logic [2:0] z);
    @(posedge aclk);
    sample_stb <= s;
    zero_cross <= z;
    @(posedge aclk);
    sample_stb <= 1'b0;
    zero_cross <= 3'h0;
  endtask : pulse

  task automatic t_reset_map;
    i_aea_host.rd(aea_pkg::OFS_THR, d, r);
    chk(d, 32'h3);
    chk({31'h0, interrupt_out_n}, 32'h1);
    i_aea_host.rd(aea_pkg::OFS_ETOT + 8'h08, d, r);
    chk(d, 32'h0);
    i_aea_host.rd(aea_pkg::OFS_END, d, r);
    chk({d[29:0], r}, 32'(aea_pkg::RESP_SLVERR));
    i_aea_host.wr(aea_pkg::OFS_NOMINAL_VOLTAGE_WORD, 32'hffffffff, r);
    i_aea_host.rd(aea_pkg::OFS_NOMINAL_VOLTAGE_WORD, d, r);
    chk(d, 32'h00ffffff);
  endtask : t_reset_map

  task automatic t_power;
    i_aea_host.wr(aea_pkg::OFS_THR, 32'h1, r);
    i_aea_host.wr(aea_pkg::OFS_NOMINAL_VOLTAGE_WORD, 32'(aea_pkg::RMS_FS / 2), r);
    i_aea_host.wr(aea_pkg::OFS_COMP, 32'h1000, r);
    meas[0] <= {2{24'(aea_pkg::RMS_FS)}};
    meas[1] <= {24'h000000, 24'(aea_pkg::RMS_FS)};
    pulse(1'b1, 3'h0);
    i_aea_host.rd(aea_pkg::OFS_IPWR, d, r);
    near(d, int'(aea_pkg::FULL_SCALE_POWER_CONSTANT / 16), 2);
    i_aea_host.rd(aea_pkg::OFS_IPWR + 8'h04, d, r);
    near(d, int'(aea_pkg::FULL_SCALE_POWER_CONSTANT / 32), 2);
    i_aea_host.wr(aea_pkg::OFS_GAIN, 32'h00400000, r);
    pulse(1'b1, 3'h0);
    i_aea_host.rd(aea_pkg::OFS_IPWR, d, r);
    near(d, int'(aea_pkg::FULL_SCALE_POWER_CONSTANT * 3 / 32), 2);
    i_aea_host.wr(aea_pkg::OFS_GAIN, 32'h0, r);
    pulse(1'b1, 3'h0);
  endtask : t_power

  task automatic t_energy;
    n0 = npulse;
    repeat (40000) @(posedge aclk);
    near(32'(npulse - n0), int'((longint'(40000 * 1024 / 100000) * (aea_pkg::FULL_SCALE_POWER_CONSTANT / 16)) >>> 27), 1);
    i_aea_host.wr(aea_pkg::OFS_LCYC, 32'h40, r);
    i_aea_host.rd(aea_pkg::OFS_ETOT, d, r);
    chk(d, 32'(npulse));
    i_aea_host.rd(aea_pkg::OFS_ETOT, d, r);
    chk(d, 32'h0);
  endtask : t_energy

  task automatic t_line_mode;
    i_aea_host.wr(aea_pkg::OFS_HALF_CYCLE_COUNT_WORD, 32'h2, r);
    i_aea_host.wr(aea_pkg::OFS_LCYC, 32'h0c, r);
    i_aea_host.rd(aea_pkg::OFS_ETOT, d0, r);
    repeat (8000) @(posedge aclk);
    pulse(1'b0, 3'b110);
    pulse(1'b0, 3'b001);
    i_aea_host.rd(aea_pkg::OFS_ETOT, d, r);
    chk(d, d0);
    repeat (8000) @(posedge aclk);
    pulse(1'b0, 3'b001);
    i_aea_host.rd(aea_pkg::OFS_ETOT, d, r);
    chk({31'h0, d !== d0}, 32'h1);
  endtask : t_line_mode

  initial begin
    #1000000;
    fails++;
    results();
  end

  initial begin
    aresetn = 1'b0;
    meas = '0;
    sample_stb = 1'b0;
    zero_cross = 3'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_map();
    t_power();
    t_energy();
    t_line_mode();
    results();
  end
endmodule : aea_apparent_energy_test
`default_nettype wire
